// file: verilog/fac_aux_decoder.v
// Auxiliary command decoder and result generator
`timescale 1ns/1ps
`include "fac_map.vh"
// Notes on behaviour
// - Configure opcode then an all-zero byte
// - Third byte: seek, fifo, poll, threshold
// - Fourth byte stores precompensation start track
// - Dump opcode queues internal parameter registers
// - Dump returns ten bytes in fixed order
// - After format, dump shows sectors per track
// - After read/write, dump shows final sector
// - Read ID: density flag, head/unit byte
// - First good ID field captured into data
// - Read ID returns three status, four ID
// - Perpendicular: overwrite, drives, gap, write gate
// - Unknown opcode: no-op, single byte 80H
// - Unknown opcode puts device in standby
// - Lock command stores requested lock bit
// - Lock result shows lock in D4
// - Unit select stays internal, no pins
module fac_aux_decoder #(
  parameter DRIVES = 4,
  parameter DUMP_LEN = 10
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Register port
  input wire [1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData_q,
  // Settings held by neighbouring command logic
  input wire [7:0] stepRateUnload,
  input wire [7:0] headLoadNonDma,
  input wire lastCmdFormat,
  input wire [7:0] sectorsPerTrack,
  input wire [7:0] finalSectorNumber,
  // Identification field reader
  output reg idStart_q,
  output reg idDoubleDensity_q,
  output reg idHeadSel_q,
  output reg [1:0] idUnit_q,
  input wire idDone,
  input wire [7:0] idStatusZero,
  input wire [7:0] idStatusOne,
  input wire [7:0] idStatusTwo,
  input wire [7:0] idCyl,
  input wire [7:0] idHead,
  input wire [7:0] idRec,
  input wire [7:0] idSize,
  // Internal stepper request
  output reg seekStart_q,
  output reg [1:0] seekUnit_q,
  output reg seekDir_q,
  output reg [7:0] seekCount_q,
  // Stored settings
  output reg autoSeekEnable_q,
  output reg fifoDisable_q,
  output reg pollDisable_q,
  output reg [3:0] fifoThreshold_q,
  output reg [7:0] precompStartTrack_q,
  output reg [5:0] perpMode_q,
  output reg lock_q,
  output reg standby_q
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_PARAM = 4'b0010;
  localparam ST_WAITID = 4'b0100;
  localparam ST_RESULT = 4'b1000;

  reg [3:0] state_q;
  reg [2:0] cls_q;
  reg [1:0] need_q;
  reg [1:0] idx_q;
  reg [7:0] opByte_q;
  reg [1:0] unit_q;
  reg [3:0] resCnt_q;
  reg [3:0] rdPtr_q;
  reg [7:0] res_q [0:DUMP_LEN-1];
  reg [7:0] pcn_q [0:DRIVES-1];
  wire [2:0] opCls;
  wire [1:0] opParams;
  wire [7:0] seekTarget;
  wire dataWr;
  wire dataRd;
  wire softRst;
  integer i;

  assign dataWr = regWrite && (regAddr == `FAC_ADDR_DATA);
  assign dataRd = regRead && (regAddr == `FAC_ADDR_DATA);
  assign softRst = regWrite && (regAddr == `FAC_ADDR_CTRL) && regWrData[`FAC_CTRL_SWRST];

  // Opcode decode
  fac_opcode_class uClass (
    .opcode(regWrData),
    .cls(opCls),
    .nParam(opParams)
  );

  // Seek target
  fac_seek_calc uSeek (
    .curCyl(pcn_q[unit_q]),
    .stepCount(regWrData),
    .stepIn(opByte_q[`FAC_BIT_DIR]),
    .newCyl(seekTarget)
  );

  // Read data, valid only the cycle after a read strobe
  always @(posedge clk) begin
    if (srst) begin
      regRdData_q <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `FAC_ADDR_DATA: begin
          regRdData_q <= state_q[3] ? res_q[rdPtr_q] : 8'h00;
        end
        `FAC_ADDR_STAT: begin
          regRdData_q <= {4'h0, lock_q, standby_q, state_q[3], ~state_q[0]};
        end
        default: begin
          regRdData_q <= 8'h00;
        end
      endcase
    end else begin
      regRdData_q <= 8'h00;
    end
  end

  // Command sequencing
  always @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cls_q <= `FAC_CLS_BAD;
      need_q <= `FAC_NPAR_NONE;
      idx_q <= 2'h0;
      opByte_q <= 8'h00;
      unit_q <= 2'h0;
      resCnt_q <= 4'h0;
      rdPtr_q <= 4'h0;
      idStart_q <= 1'b0;
      idDoubleDensity_q <= 1'b0;
      idHeadSel_q <= 1'b0;
      idUnit_q <= 2'h0;
      seekStart_q <= 1'b0;
      seekUnit_q <= 2'h0;
      seekDir_q <= 1'b0;
      seekCount_q <= 8'h00;
      {autoSeekEnable_q, fifoDisable_q, pollDisable_q, fifoThreshold_q} <= `FAC_CFG_RST;
      precompStartTrack_q <= `FAC_PRECOMP_START_TRACK_RST;
      perpMode_q <= `FAC_PERP_RST;
      lock_q <= 1'b0;
      standby_q <= 1'b0;
      for (i = 0; i < DUMP_LEN; i = i + 1) begin
        res_q[i] <= 8'h00;
      end
      for (i = 0; i < DRIVES; i = i + 1) begin
        pcn_q[i] <= `FAC_PCN_RST;
      end
    end else if (softRst) begin
      state_q <= ST_IDLE;
      idStart_q <= 1'b0;
      seekStart_q <= 1'b0;
      rdPtr_q <= 4'h0;
      if (!lock_q) begin
        {autoSeekEnable_q, fifoDisable_q, pollDisable_q, fifoThreshold_q} <= `FAC_CFG_RST;
        precompStartTrack_q <= `FAC_PRECOMP_START_TRACK_RST;
      end
    end else begin
      idStart_q <= 1'b0;
      seekStart_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (dataWr) begin
            opByte_q <= regWrData;
            cls_q <= opCls;
            need_q <= opParams;
            idx_q <= 2'h0;
            rdPtr_q <= 4'h0;
            standby_q <= 1'b0;
            case (opCls)
              `FAC_CLS_DUMP: begin
                for (i = 0; i < DRIVES; i = i + 1) begin
                  res_q[i] <= pcn_q[i];
                end
                res_q[4] <= stepRateUnload;
                res_q[5] <= headLoadNonDma;
                res_q[6] <= lastCmdFormat ? sectorsPerTrack : finalSectorNumber;
                res_q[7] <= {lock_q, 1'b0, perpMode_q};
                res_q[8] <= {1'b0, autoSeekEnable_q, fifoDisable_q, pollDisable_q, fifoThreshold_q};
                res_q[9] <= precompStartTrack_q;
                resCnt_q <= `FAC_LEN_DUMP;
                state_q <= ST_RESULT;
              end
              `FAC_CLS_LOCK: begin
                lock_q <= regWrData[`FAC_BIT_LOCK];
                res_q[0] <= {3'h0, regWrData[`FAC_BIT_LOCK], 4'h0};
                resCnt_q <= `FAC_LEN_ONE;
                state_q <= ST_RESULT;
              end
              `FAC_CLS_BAD: begin
                res_q[0] <= `FAC_ST0_INVALID;
                resCnt_q <= `FAC_LEN_ONE;
                standby_q <= 1'b1;
                state_q <= ST_RESULT;
              end
              default: begin
                state_q <= ST_PARAM;
              end
            endcase
          end
        end
        ST_PARAM: begin
          if (dataWr) begin
            idx_q <= idx_q + 2'h1;
            if (idx_q == need_q - 2'h1) begin
              state_q <= ST_IDLE;
            end
            case (cls_q)
              `FAC_CLS_CFG: begin
                if (idx_q == 2'h1) begin
                  {autoSeekEnable_q, fifoDisable_q, pollDisable_q, fifoThreshold_q} <= regWrData[6:0];
                end else if (idx_q == 2'h2) begin
                  precompStartTrack_q <= regWrData;
                end
              end
              `FAC_CLS_SEEK: begin
                if (idx_q == 2'h0) begin
                  unit_q <= regWrData[1:0];
                end else begin
                  pcn_q[unit_q] <= seekTarget;
                  seekStart_q <= 1'b1;
                  seekUnit_q <= unit_q;
                  seekDir_q <= opByte_q[`FAC_BIT_DIR];
                  seekCount_q <= regWrData;
                end
              end
              `FAC_CLS_RID: begin
                idDoubleDensity_q <= opByte_q[`FAC_BIT_DD];
                idHeadSel_q <= regWrData[`FAC_BIT_HEAD];
                idUnit_q <= regWrData[1:0];
                idStart_q <= 1'b1;
                state_q <= ST_WAITID;
              end
              `FAC_CLS_PERP: begin
                // Drive bits only with overwrite flag
                perpMode_q[1:0] <= regWrData[1:0];
                if (regWrData[`FAC_BIT_OVERWRITE]) begin
                  perpMode_q[5:2] <= regWrData[5:2];
                end
              end
              default: begin
                state_q <= ST_IDLE;
              end
            endcase
          end
        end
        ST_WAITID: begin
          if (idDone) begin
            res_q[0] <= idStatusZero;
            res_q[1] <= idStatusOne;
            res_q[2] <= idStatusTwo;
            res_q[3] <= idCyl;
            res_q[4] <= idHead;
            res_q[5] <= idRec;
            res_q[6] <= idSize;
            resCnt_q <= `FAC_LEN_RID;
            rdPtr_q <= 4'h0;
            state_q <= ST_RESULT;
          end
        end
        ST_RESULT: begin
          if (dataRd) begin
            rdPtr_q <= rdPtr_q + 4'h1;
            if (rdPtr_q == resCnt_q - 4'h1) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // fac_aux_decoder

// file: verilog/fac_map.vh
// Constants for the auxiliary command decoder
`ifndef FAC_MAP_VH
`define FAC_MAP_VH
// Register port addresses
`define FAC_ADDR_DATA 2'h0
`define FAC_ADDR_STAT 2'h1
`define FAC_ADDR_CTRL 2'h2
// Control register bit
`define FAC_CTRL_SWRST 0
// Opcode values and masks
`define FAC_OP_CFG 8'h13
`define FAC_OP_DUMP 8'h0E
`define FAC_OP_PERP 8'h12
`define FAC_OP_SEEK 8'h8F
`define FAC_OP_RID 8'h0A
`define FAC_OP_LOCK 8'h14
`define FAC_MASK_FLAG6 8'hBF
`define FAC_MASK_FLAG7 8'h7F
// Command classes
`define FAC_CLS_CFG 3'h0
`define FAC_CLS_SEEK 3'h1
`define FAC_CLS_DUMP 3'h2
`define FAC_CLS_RID 3'h3
`define FAC_CLS_PERP 3'h4
`define FAC_CLS_LOCK 3'h5
`define FAC_CLS_BAD 3'h6
// Parameter byte counts
`define FAC_NPAR_CFG 2'h3
`define FAC_NPAR_SEEK 2'h2
`define FAC_NPAR_ONE 2'h1
`define FAC_NPAR_NONE 2'h0
// Result values and lengths
`define FAC_ST0_INVALID 8'h80
`define FAC_LEN_DUMP 4'hA
`define FAC_LEN_RID 4'h7
`define FAC_LEN_ONE 4'h1
// Reset values of stored settings
`define FAC_CFG_RST 7'h00
`define FAC_PRECOMP_START_TRACK_RST 8'h00
`define FAC_PERP_RST 6'h00
`define FAC_PCN_RST 8'h00
// Byte fields
`define FAC_BIT_DIR 6
`define FAC_BIT_DD 6
`define FAC_BIT_HEAD 2
`define FAC_BIT_LOCK 7
`define FAC_BIT_OVERWRITE 7
`define FAC_CYL_MAX 8'hFF
`endif

// file: verilog/fac_opcode_class.v
// Opcode classifier with parameter byte count
`timescale 1ns/1ps
`include "fac_map.vh"
module fac_opcode_class (
  // Opcode in
  input wire [7:0] opcode,
  // Class out
  output reg [2:0] cls,
  output reg [1:0] nParam
);
  always @* begin
    cls = `FAC_CLS_BAD;
    nParam = `FAC_NPAR_NONE;
    if (opcode == `FAC_OP_CFG) begin
      cls = `FAC_CLS_CFG;
      nParam = `FAC_NPAR_CFG;
    end else if ((opcode & `FAC_MASK_FLAG6) == `FAC_OP_SEEK) begin
      cls = `FAC_CLS_SEEK;
      nParam = `FAC_NPAR_SEEK;
    end else if (opcode == `FAC_OP_DUMP) begin
      cls = `FAC_CLS_DUMP;
    end else if ((opcode & `FAC_MASK_FLAG6) == `FAC_OP_RID) begin
      cls = `FAC_CLS_RID;
      nParam = `FAC_NPAR_ONE;
    end else if (opcode == `FAC_OP_PERP) begin
      cls = `FAC_CLS_PERP;
      nParam = `FAC_NPAR_ONE;
    end else if ((opcode & `FAC_MASK_FLAG7) == `FAC_OP_LOCK) begin
      cls = `FAC_CLS_LOCK;
    end
  end
endmodule // fac_opcode_class

// file: verilog/fac_seek_calc.v
// Relative seek target cylinder arithmetic
`timescale 1ns/1ps
`include "fac_map.vh"
module fac_seek_calc (
  // Operands
  input wire [7:0] curCyl,
  input wire [7:0] stepCount,
  input wire stepIn,
  // Result
  output wire [7:0] newCyl
);
  function [7:0] stepCyl;
    input [7:0] cur;
    input [7:0] cnt;
    input dirIn;
    reg [8:0] sum;
    begin
      sum = {1'b0, cur} + {1'b0, cnt};
      if (dirIn) begin
        stepCyl = sum[8] ? `FAC_CYL_MAX : sum[7:0];
      end else begin
        stepCyl = (cnt > cur) ? `FAC_PCN_RST : cur - cnt;
      end
    end
  endfunction
  assign newCyl = stepCyl(curCyl, stepCount, stepIn);
endmodule // fac_seek_calc

// file: testbench/fac_aux_decoder_chk.sv
// Port checker for the auxiliary command decoder
`timescale 1ns/1ps
module fac_aux_decoder_chk (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Register port
  input wire [1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData_q,
  // Requests
  input wire idStart_q,
  input wire idHeadSel_q,
  input wire [1:0] idUnit_q,
  input wire seekStart_q,
  input wire [7:0] seekCount_q,
  // Settings
  input wire autoSeekEnable_q,
  input wire fifoDisable_q,
  input wire pollDisable_q,
  input wire [3:0] fifoThreshold_q,
  input wire [7:0] precompStartTrack_q,
  input wire lock_q,
  input wire standby_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire dataWr = regWrite && regAddr == 2'h0;
  wire swReset = regWrite && regAddr == 2'h2 && regWrData[0];
  wire [14:0] cfg = {autoSeekEnable_q, fifoDisable_q, pollDisable_q, fifoThreshold_q, precompStartTrack_q};
  a_rd_slot_only: assert property (!$past(regRead) |-> regRdData_q == 8'h00)
    else $error("read data outside read slot");
  a_seek_count: assert property (seekStart_q |-> $past(dataWr) && seekCount_q == $past(regWrData))
    else $error("seek count not from last byte");
  a_seek_pulse: assert property (seekStart_q |=> !seekStart_q)
    else $error("seek start longer than one cycle");
  a_id_select: assert property (idStart_q |-> $past(dataWr) && {idHeadSel_q, idUnit_q} == $past(regWrData[2:0]))
    else $error("id head or unit wrong");
  a_lock_set: assert property ($rose(lock_q) |-> $past(dataWr && regWrData == 8'h94))
    else $error("lock set without command");
  a_lock_clear: assert property ($fell(lock_q) |-> $past(srst) || $past(dataWr && regWrData == 8'h14))
    else $error("lock cleared without command");
  a_standby_cause: assert property ($rose(standby_q) |-> $past(dataWr))
    else $error("standby without opcode");
  a_lock_keeps: assert property ($past(lock_q && swReset && !srst) |-> $stable(cfg))
    else $error("locked settings lost");
  a_unlock_clears: assert property ($past(!lock_q && swReset && !srst) |-> cfg == 15'h0000)
    else $error("settings not cleared");
  a_cfg_cause: assert property (!$stable(cfg) |-> $past(regWrite || srst))
    else $error("settings changed without write");
  c_seek: cover property (seekStart_q);
  c_id: cover property (idStart_q);
  c_invalid: cover property ($rose(standby_q));
endmodule // fac_aux_decoder_chk
bind fac_aux_decoder fac_aux_decoder_chk u_chk (.clk, .srst, .regAddr, .regWrData, .regWrite, .regRead,
  .regRdData_q, .idStart_q, .idHeadSel_q, .idUnit_q, .seekStart_q, .seekCount_q, .autoSeekEnable_q,
  .fifoDisable_q, .pollDisable_q, .fifoThreshold_q, .precompStartTrack_q, .lock_q, .standby_q);

// file: testbench/fac_id_model.sv
// Identification field reader model
`timescale 1ns/1ps
module fac_id_model (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Search request
  input wire idStart,
  input wire [7:0] base,
  input wire [7:0] delay,
  // Field answer
  output logic idDone,
  output logic [7:0] idByte [7]
);
  logic [7:0] cnt;
  always @(posedge clk) begin
    if (srst) begin
      cnt <= 8'h00;
      idDone <= 1'b0;
    end else begin
      idDone <= cnt == 8'h01;
      if (idStart) begin
        cnt <= delay;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
  always_comb begin
    for (int k = 0; k < 7; k++) idByte[k] = idDone ? base + 8'(k) : ~(base + 8'(k));
  end
endmodule // fac_id_model

// file: testbench/fac_aux_decoder_tb.sv
// Self-checking bench for the auxiliary command decoder
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, a); end end
module fac_aux_decoder_tb;
  logic clk = 0, srst = 1, regWrite = 0, regRead = 0, lastFmt = 1;
  logic [1:0] regAddr = 0;
  logic [7:0] regWrData = 0, rdData, idBase = 0, idDelay = 1;
  logic [7:0] idB [7];
  logic [7:0] dumpExp [10] = '{8'hFF, 8'h03, 8'h00, 8'h00, 8'hA1, 8'hB2, 8'h12, 8'h0D, 8'h6B, 8'h37};
  logic [7:0] bad [3] = '{8'h00, 8'hFF, 8'h1F};
  wire [7:0] regRdData_q, seekCount_q, precompStartTrack_q;
  wire [5:0] perpMode_q;
  wire [3:0] fifoThreshold_q;
  wire [1:0] idUnit_q, seekUnit_q;
  wire idStart_q, idDoubleDensity_q, idHeadSel_q, idDone, seekStart_q, seekDir_q, autoSeekEnable_q;
  wire fifoDisable_q, pollDisable_q, lock_q, standby_q;
  int error_cnt = 0, n_compared = 0;
  always #20 clk = ~clk;
  fac_id_model u_id (.clk, .srst, .idStart(idStart_q), .base(idBase), .delay(idDelay), .idDone, .idByte(idB));
  fac_aux_decoder dut (.clk, .srst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData_q,
    .stepRateUnload(8'hA1), .headLoadNonDma(8'hB2), .lastCmdFormat(lastFmt), .sectorsPerTrack(8'h12),
    .finalSectorNumber(8'h24), .idStart_q, .idDoubleDensity_q, .idHeadSel_q, .idUnit_q, .idDone,
    .idStatusZero(idB[0]), .idStatusOne(idB[1]), .idStatusTwo(idB[2]), .idCyl(idB[3]), .idHead(idB[4]),
    .idRec(idB[5]), .idSize(idB[6]), .seekStart_q, .seekUnit_q, .seekDir_q, .seekCount_q, .autoSeekEnable_q,
    .fifoDisable_q, .pollDisable_q, .fifoThreshold_q, .precompStartTrack_q, .perpMode_q, .lock_q, .standby_q);
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b [$]);
    foreach (b[k]) wr(2'h0, b[k]);
    #1;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    rdData = regRdData_q;
  endtask
  task automatic rc(input logic [1:0] a, input logic [7:0] e, input string n);
    rd(a);
    `CHK(n, e, rdData)
  endtask
  task automatic dump;
    send('{8'h0E});
    for (int k = 0; k < 10; k++) rc(2'h0, dumpExp[k], "dump byte");
  endtask
  task automatic rid(input logic [7:0] op, input logic [7:0] hu, input logic [7:0] dl);
    @(posedge clk);
    idDelay <= dl;
    idBase <= dl + 8'h30;
    send('{op, hu});
    rdData = 8'h00;
    for (int i = 0; i < 60 && rdData[1] !== 1'b1; i++) rd(2'h1);
    `CHK("id select", {op[6], hu[2:0]}, {idDoubleDensity_q, idHeadSel_q, idUnit_q})
    for (int k = 0; k < 7; k++) rc(2'h0, dl + 8'h30 + 8'(k), "id byte");
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    wr(2'h3, 8'hFF);
    rc(2'h1, 8'h00, "status");
    rc(2'h3, 8'h00, "unmapped");
    rc(2'h0, 8'h00, "no result");
    $display("test reset done");
    send('{8'h13, 8'h00, 8'h6B, 8'h37});
    `CHK("config", 7'h6B, {autoSeekEnable_q, fifoDisable_q, pollDisable_q, fifoThreshold_q})
    `CHK("pretrack", 8'h37, precompStartTrack_q)
    $display("test configure done");
    send('{8'hCF, 8'h01, 8'h05});
    send('{8'h8F, 8'h01, 8'h02});
    send('{8'h8F, 8'h02, 8'h03});
    send('{8'hCF, 8'h00, 8'hFF});
    send('{8'h12, 8'h8D});
    `CHK("seek", 11'h4FF, {seekDir_q, seekUnit_q, seekCount_q})
    `CHK("perp", 6'h0D, perpMode_q)
    dump;
    @(posedge clk);
    lastFmt <= 1'b0;
    dumpExp[6] = 8'h24;
    dump;
    $display("test seek and dump done");
    send('{8'h94});
    rc(2'h0, 8'h10, "lock result");
    wr(2'h2, 8'h01);
    #1;
    `CHK("kept", 15'h6B37, {autoSeekEnable_q, fifoDisable_q, pollDisable_q, fifoThreshold_q, precompStartTrack_q})
    dumpExp[7] = 8'h8D;
    dump;
    send('{8'h14});
    rc(2'h0, 8'h00, "unlock result");
    wr(2'h2, 8'h01);
    #1;
    `CHK("cleared", 15'h0000, {autoSeekEnable_q, fifoDisable_q, pollDisable_q, fifoThreshold_q, precompStartTrack_q})
    $display("test lock done");
    rid(8'h4A, 8'h06, 8'h01);
    rid(8'h0A, 8'h01, 8'h14);
    $display("test read id done");
    foreach (bad[k]) begin
      send('{bad[k]});
      rc(2'h0, 8'h80, "invalid");
      `CHK("standby", 1'b1, standby_q)
    end
    send('{8'h94});
    rc(2'h0, 8'h10, "lock again");
    `CHK("standby off", 1'b0, standby_q)
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("hard reset", 2'b00, {lock_q, standby_q})
    $display("test invalid and reset done");
    report_and_stop;
  end
endmodule // fac_aux_decoder_tb
